// ===== verilog/spx_pkg.sv
package spx_pkg;

    // -------------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------------
    localparam int         SPX_AW        = 8;
    localparam logic [7:0] SPX_OFF_CTRL  = 8'h00;
    localparam logic [7:0] SPX_OFF_STAT  = 8'h04;
    localparam logic [7:0] SPX_OFF_DATA  = 8'h08;

    // Control register bits.
    localparam int SPX_C_RXIE = 0;
    localparam int SPX_C_MSTR = 1;
    localparam int SPX_C_CLOCK_POLARITY_BIT = 2;
    localparam int SPX_C_CLOCK_PHASE_BIT = 3;
    localparam int SPX_C_MFEN = 4;
    localparam int SPX_C_TXIE = 5;
    localparam int SPX_C_EN   = 6;
    localparam int SPX_C_ERIE = 7;
    localparam logic [7:0] SPX_CTRL_RST = 8'h00;

    // Status register bits.
    localparam int SPX_S_RLO  = 0;
    localparam int SPX_S_RHI  = 1;
    localparam int SPX_S_TXE  = 3;
    localparam int SPX_S_MODF = 4;
    localparam int SPX_S_OVF  = 6;
    localparam int SPX_S_RXF  = 7;
    localparam logic [1:0] SPX_RATE_RST = 2'h0;

    // -------------------------------------------------------------------------
    // Transfer shape and timing
    // -------------------------------------------------------------------------
    localparam int         SPX_BITS      = 8;
    localparam logic [3:0] SPX_LAST_EDGE = 4'hF;
    localparam int         SPX_BIT_DIV [4] = '{2, 8, 32, 128};
    localparam int         SPX_DIV_W     = 7;

    localparam logic [1:0] SPX_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SPX_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SPX_IDLE,
        SPX_WAIT,
        SPX_RUN
    } spx_state_e;

endpackage

// ===== verilog/spx_baud_if.sv
`timescale 1ns/1ps
`default_nettype none

interface spx_baud_if;
    logic       run;
    logic [1:0] rate;
    logic       tick;

    modport core (output run, output rate, input tick);
    modport gen  (input run, input rate, output tick);
endinterface // spx_baud_if

`default_nettype wire

// ===== verilog/spx_baud.sv
`timescale 1ns/1ps
`default_nettype none

module spx_baud
    import spx_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Rate control
    spx_baud_if.gen   bif
);

    logic [SPX_DIV_W-1:0] div_ff;
    logic [SPX_DIV_W-1:0] nxt_div;
    logic [SPX_DIV_W-1:0] half_lim;

    // One tick per half bit time, so the fastest rate gives a bit every two cycles.
    // rate selection
    assign half_lim = SPX_DIV_W'(SPX_BIT_DIV[bif.rate] / 2 - 1);
    assign bif.tick = bif.run & (div_ff == half_lim);
    assign nxt_div  = (!bif.run || bif.tick) ? '0 : div_ff + SPX_DIV_W'(1);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

endmodule // spx_baud

`default_nettype wire

// ===== verilog/spx_core.sv
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module spx_core
    import spx_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // AXI4-Lite write channels
    input  wire logic [SPX_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [SPX_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Serial pins
    input  wire logic              shift_clock_pin_i,
    output logic                   shift_clock_pin_o,
    output logic                   shift_clock_pin_oe_n,
    input  wire logic              mosi_i,
    output logic                   mosi_o,
    output logic                   mosi_oe_n,
    input  wire logic              miso_i,
    output logic                   miso_o,
    output logic                   miso_oe_n,
    input  wire logic              ss_n_i,
    // Interrupt requests
    output logic                   rx_full_irq,
    output logic                   tx_empty_irq,
    output logic                   error_irq
);

    // -------------------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------------------
    function automatic logic [1:0] reg_sel(input logic [SPX_AW-1:0] addr);
        logic [1:0] sel;
        sel = 2'h3;
        if (addr == SPX_OFF_CTRL) begin
            sel = 2'h0;
        end else if (addr == SPX_OFF_STAT) begin
            sel = 2'h1;
        end else if (addr == SPX_OFF_DATA) begin
            sel = 2'h2;
        end
        return sel;
    endfunction

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    logic [7:0]       ctrl_ff;
    logic [1:0]       rate_ff;
    logic [7:0]       tx_buf_ff;
    logic             tx_full_ff;
    logic             tx_buffer_empty_flag_ff;
    logic [7:0]       rx_data_ff;
    logic             rx_buffer_full_flag_ff;
    logic             ovf_ff;
    logic             modf_ff;
    logic             armed_ff;
    logic [7:0]       sh_ff;
    logic             samp_ff;
    logic [3:0]       cnt_ff;
    logic             lvl_ff;
    logic             sck_q_ff;
    logic             ss_q_ff;
    spx_state_e       st_ff;
    spx_state_e       nxt_st;

    logic             aw_ok_ff;
    logic             w_ok_ff;
    logic [SPX_AW-1:0] awaddr_ff;
    logic [31:0]      wdata_ff;
    logic             wlane_ff;
    logic             bvalid_ff;
    logic [1:0]       bresp_ff;
    logic             rvalid_ff;
    logic [31:0]      rdata_ff;
    logic [1:0]       rresp_ff;

    spx_baud_if bif ();

    spx_baud u_baud (
        .clock (clock),
        .rst_n (rst_n),
        .bif   (bif)
    );

    // -------------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------------
    wire       wr_go   = aw_ok_ff & w_ok_ff & !bvalid_ff;
    wire [1:0] wr_sel  = reg_sel(awaddr_ff);
    wire       ar_go   = s_axi_arvalid & !rvalid_ff;
    wire [1:0] rd_sel  = reg_sel(s_axi_araddr);
    wire       wr_en   = wr_go & wlane_ff;
    wire       wr_ctrl = wr_en & (wr_sel == 2'h0);
    wire       wr_stat = wr_en & (wr_sel == 2'h1);
    wire       wr_data = wr_en & (wr_sel == 2'h2);
    wire       rd_stat = ar_go & (rd_sel == 2'h1);
    wire       rd_data = ar_go & (rd_sel == 2'h2);

    // -------------------------------------------------------------------------
    // Mode and pin logic
    // -------------------------------------------------------------------------
    wire clock_phase_bit      = ctrl_ff[SPX_C_CLOCK_PHASE_BIT];
    wire clock_polarity_bit      = ctrl_ff[SPX_C_CLOCK_POLARITY_BIT];
    wire master_on = ctrl_ff[SPX_C_EN] & ctrl_ff[SPX_C_MSTR];
    wire slave_on  = ctrl_ff[SPX_C_EN] & !ctrl_ff[SPX_C_MSTR];
    wire selected  = slave_on & !ss_n_i;
    // Pin inputs are synchronous to the clock, so a change of level is a clock edge.
    // clock up to half bus rate
    wire s_edge    = selected & (shift_clock_pin_i != sck_q_ff);
    wire ss_fall   = ss_q_ff & !ss_n_i;
    wire din       = master_on ? miso_i : mosi_i;
    wire contend   = master_on & ctrl_ff[SPX_C_MFEN] & !ss_n_i;

    assign bif.run  = master_on;
    assign bif.rate = rate_ff;

    // -------------------------------------------------------------------------
    // Transfer sequencing
    // -------------------------------------------------------------------------
    // immediate load
    wire load_m  = master_on & (st_ff == SPX_IDLE) & tx_full_ff & !contend;
    wire s_begin = selected & (st_ff == SPX_IDLE) & (clock_phase_bit ? s_edge : ss_fall);
    wire load_s  = s_begin & tx_full_ff;
    wire m_edge  = master_on & bif.tick & ((st_ff == SPX_RUN) | ((st_ff == SPX_WAIT) & clock_phase_bit));
    wire edge_go = master_on ? m_edge : (s_edge & ((st_ff == SPX_RUN) | s_begin));
    wire samp_e  = (cnt_ff[0] == clock_phase_bit);
    wire shift_e = !samp_e & !(clock_phase_bit & (cnt_ff == '0));
    wire done    = edge_go & (cnt_ff == SPX_LAST_EDGE);
    wire [7:0] rx_byte = {sh_ff[SPX_BITS-2:0], clock_phase_bit ? din : samp_ff};
    wire abort   = !ctrl_ff[SPX_C_EN] | contend | (slave_on & ss_n_i);

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            SPX_IDLE: begin
                if (load_m) begin
                    nxt_st = SPX_WAIT;
                end else if (s_begin) begin
                    nxt_st = SPX_RUN;
                end
            end
            SPX_WAIT: begin
                if (bif.tick) begin
                    nxt_st = SPX_RUN;
                end
            end
            SPX_RUN: begin
                if (done) begin
                    nxt_st = SPX_IDLE;
                end
            end
            default: nxt_st = SPX_IDLE;
        endcase
        if (abort) begin
            nxt_st = SPX_IDLE;
        end
    end

    wire [3:0] nxt_cnt = (abort | done) ? 4'h0 : (edge_go ? cnt_ff + 4'h1 : cnt_ff);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff    <= SPX_IDLE;
            cnt_ff   <= 4'h0;
            sck_q_ff <= 1'b0;
            ss_q_ff  <= 1'b1;
        end else begin
            st_ff    <= nxt_st;
            cnt_ff   <= nxt_cnt;
            sck_q_ff <= shift_clock_pin_i;
            ss_q_ff  <= ss_n_i;
        end
    end

    // Shift path: the received byte stays in the shifter, and a slave sends it out if nothing new is queued.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sh_ff   <= 8'h00;
            samp_ff <= 1'b0;
            lvl_ff  <= 1'b0;
        end else begin
            if (load_m | load_s) begin
                sh_ff <= tx_buf_ff;
            end else if (done) begin
                sh_ff <= rx_byte;
            end else if (edge_go & shift_e) begin
                sh_ff <= {sh_ff[SPX_BITS-2:0], samp_ff};
            end
            if (edge_go & samp_e) begin
                samp_ff <= din;
            end
            if (abort) begin
                lvl_ff <= 1'b0;
            end else if (m_edge) begin
                lvl_ff <= !lvl_ff;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Buffers and flags
    // -------------------------------------------------------------------------
    // two-step clear
    wire rd_clear  = rd_data & armed_ff;
    wire rx_held   = rx_buffer_full_flag_ff & !rd_clear;
    wire ovf_hit   = done & rx_held;
    wire tx_move   = load_m | load_s;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_buf_ff               <= 8'h00;
            tx_full_ff              <= 1'b0;
            tx_buffer_empty_flag_ff <= 1'b1;
            rx_data_ff              <= 8'h00;
            rx_buffer_full_flag_ff  <= 1'b0;
            ovf_ff                  <= 1'b0;
            modf_ff                 <= 1'b0;
            armed_ff                <= 1'b0;
        end else begin
            if (wr_data) begin
                tx_buf_ff               <= wdata_ff[SPX_BITS-1:0];
                tx_full_ff              <= 1'b1;
                tx_buffer_empty_flag_ff <= 1'b0;
            end else if (tx_move) begin
                tx_full_ff              <= 1'b0;
                tx_buffer_empty_flag_ff <= 1'b1;
            end
            if (done & !rx_held) begin
                rx_data_ff <= rx_byte;
            end
            rx_buffer_full_flag_ff <= done | rx_held;
            ovf_ff  <= ovf_hit | (ovf_ff & !rd_clear);
            modf_ff <= contend | (modf_ff & !(wr_stat & wdata_ff[SPX_S_MODF]));
            if (rd_stat & (rx_buffer_full_flag_ff | ovf_ff)) begin
                armed_ff <= 1'b1;
            end else if (rd_data) begin
                armed_ff <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Register bus
    // -------------------------------------------------------------------------
    wire [7:0] stat_byte = {rx_buffer_full_flag_ff, ovf_ff, 1'b0, modf_ff,
                            tx_buffer_empty_flag_ff, 1'b0, rate_ff};
    wire [7:0] rd_byte   = (rd_sel == 2'h0) ? ctrl_ff :
                           (rd_sel == 2'h1) ? stat_byte :
                           (rd_sel == 2'h2) ? rx_data_ff : 8'h00;

    assign s_axi_awready = !aw_ok_ff & !bvalid_ff;
    assign s_axi_wready  = !w_ok_ff & !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_ok_ff  <= 1'b0;
            w_ok_ff   <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff  <= 32'h0;
            wlane_ff  <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= SPX_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_ok_ff  <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_ok_ff  <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wlane_ff <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_ok_ff  <= 1'b0;
                w_ok_ff   <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= (wr_sel == 2'h3) ? SPX_RESP_SLVERR : SPX_RESP_OKAY;
            end else if (bvalid_ff & s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0;
            rresp_ff  <= SPX_RESP_OKAY;
        end else if (ar_go) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= {24'h0, rd_byte};
            rresp_ff  <= (rd_sel == 2'h3) ? SPX_RESP_SLVERR : SPX_RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Changing phase or polarity mid-transfer corrupts the byte; software disables first.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= SPX_CTRL_RST;
            rate_ff <= SPX_RATE_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= wdata_ff[7:0];
            end
            if (wr_stat) begin
                rate_ff <= {wdata_ff[SPX_S_RHI], wdata_ff[SPX_S_RLO]};
            end
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // -------------------------------------------------------------------------
    // Pins and requests
    // -------------------------------------------------------------------------
    // idle level from polarity
    assign shift_clock_pin_o    = clock_polarity_bit ^ lvl_ff;
    assign shift_clock_pin_oe_n = !master_on;
    assign mosi_o               = sh_ff[SPX_BITS-1];
    assign mosi_oe_n            = !master_on;
    assign miso_o               = sh_ff[SPX_BITS-1];
    assign miso_oe_n            = !selected;

    assign rx_full_irq  = ctrl_ff[SPX_C_RXIE] & rx_buffer_full_flag_ff;
    assign tx_empty_irq = ctrl_ff[SPX_C_TXIE] & tx_buffer_empty_flag_ff;
    assign error_irq    = ctrl_ff[SPX_C_ERIE] & (ovf_ff | modf_ff);

endmodule // spx_core

`default_nettype wire

// ===== dv/spx_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module spx_core_assertions (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Serial pins and receive interrupt
    input wire logic        shift_clock_pin_oe_n,
    input wire logic        mosi_oe_n,
    input wire logic        miso_oe_n,
    input wire logic        ss_n_i,
    input wire logic        rx_full_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_oe_pair; shift_clock_pin_oe_n == mosi_oe_n; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("clock and data enables disagree");
    property p_one_drv; !mosi_oe_n |-> miso_oe_n; endproperty
    a_one_drv: assert property (p_one_drv) else $error("master also drives slave data");
    property p_miso_sel; !miso_oe_n |-> !ss_n_i; endproperty
    a_miso_sel: assert property (p_miso_sel) else $error("slave data driven while deselected");
    property p_quiet; ss_n_i [*2] |-> miso_oe_n; endproperty
    a_quiet: assert property (p_quiet) else $error("deselected slave disturbs the bus");
    property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    a_bans: assert property (p_bans) else $error("write response late");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_bref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_bref: assert property (p_bref) else $error("write taken while response pending");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read response late");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_rup; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_rup: assert property (p_rup) else $error("upper read bits not zero");

    c_rx_done: cover property ($rose(rx_full_irq));
    c_slave_sel: cover property (!miso_oe_n);
    c_master: cover property (!shift_clock_pin_oe_n);
endmodule // spx_core_assertions

bind spx_core spx_core_assertions chk (.*);

`default_nettype wire

// ===== dv/spx_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module spx_slave_model (
    // Reset
    input  wire logic       rst_n,
    // Serial pins
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    // Data
    input  wire logic [7:0] tx,
    output logic      [7:0] rx
);
    logic [2:0] cnt;

    assign miso = tx[3'd7 - cnt];

    always @(posedge sck) begin
        rx <= {rx[6:0], mosi};
    end

    // Advancing on the trailing edge keeps the next bit stable before the master samples it.
    always @(negedge sck or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'd0;
        end else begin
            cnt <= cnt + 3'd1;
        end
    end
endmodule // spx_slave_model

`default_nettype wire

// ===== dv/test_spi_master_slave_core.sv
`timescale 1ns/1ps
`default_nettype none

module test_spi_master_slave_core;
    import spx_pkg::*;
    logic              clock, rst_n;
    logic [SPX_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp, rr;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic              shift_clock_pin_o, shift_clock_pin_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
    logic              rx_full_irq, tx_empty_irq, error_irq, ss_n_i, ext_sck, ext_mosi;
    logic [7:0]        pm_rx, pm_tx;
    wire logic         miso_pm;
    wire logic         shift_clock_pin_i = shift_clock_pin_oe_n ? ext_sck : shift_clock_pin_o;
    wire logic         mosi_i = mosi_oe_n ? ext_mosi : mosi_o;
    wire logic         miso_i = miso_oe_n ? miso_pm : miso_o;
    int                n_errors = 0, compares = 0, n, t;

    spx_core uut (.*);
    spx_slave_model pm (.rst_n(rst_n), .sck(shift_clock_pin_i), .mosi(mosi_i), .miso(miso_pm),
                        .tx(pm_tx), .rx(pm_rx));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
    endtask

    task automatic poll(input int b);
        t = 0;
        do begin
            rd(SPX_OFF_STAT);
            t++;
        end while (rv[b] !== 1'b1 && t < 2000);
    endtask

    // Cycles between two shift clock changes.
    task automatic half();
        logic p;
        p = shift_clock_pin_o;
        for (t = 0; shift_clock_pin_o === p && t < 300; t++) @(posedge clock);
        p = shift_clock_pin_o;
        for (n = 0; shift_clock_pin_o === p && n < 300; n++) @(posedge clock);
    endtask

    task automatic end_of_test();
        $display("Counts: %0d errors, %0d compares", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        n_errors++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        pm_tx = 8'h96;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ext_sck, ext_mosi} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready, ss_n_i} = 7'h7F;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        // ---------------------------------------------------------------
        // Reset values and bus errors
        // ---------------------------------------------------------------
        rd(SPX_OFF_CTRL);
        chk(rv, {24'h0, SPX_CTRL_RST});
        rd(SPX_OFF_STAT);
        chk(rv, 32'h08);
        rd(8'h0C);
        chk(rr, SPX_RESP_SLVERR);
        wr(8'h0C, 8'h00);
        chk(s_axi_bresp, SPX_RESP_SLVERR);
        // ---------------------------------------------------------------
        // Master transfers at every rate
        // ---------------------------------------------------------------
        wr(SPX_OFF_CTRL, 8'h43);
        for (int r = 0; r < 4; r++) begin
            wr(SPX_OFF_STAT, r[7:0]);
            wr(SPX_OFF_DATA, 8'h5A ^ r[7:0]);
            half();
            chk(n, SPX_BIT_DIV[r] / 2);
            poll(SPX_S_RXF);
            chk(rx_full_irq, 1'b1);
            chk(rv[SPX_S_TXE], 1'b1);
            chk(pm_rx, 8'h5A ^ r[7:0]);
            rd(SPX_OFF_DATA);
            chk(rv, 32'h96);
            rd(SPX_OFF_STAT);
            chk(rv[SPX_S_RXF], 1'b0);
        end
        wr(SPX_OFF_DATA, 8'h11);
        wr(SPX_OFF_DATA, 8'h22);
        rd(SPX_OFF_STAT);
        chk(rv[SPX_S_TXE], 1'b0);
        poll(SPX_S_RXF);
        // A new reply for the queued byte shows whether the overflowing byte was wrongly kept.
        pm_tx <= 8'h69;
        poll(SPX_S_OVF);
        chk(rv[SPX_S_OVF], 1'b1);
        rd(SPX_OFF_DATA);
        chk(rv, 32'h96);
        chk(pm_rx, 8'h22);
        wr(SPX_OFF_CTRL, 8'hF6);
        chk(shift_clock_pin_o, 1'b1);
        chk(tx_empty_irq, 1'b1);
        ss_n_i <= 1'b0;
        repeat (2) @(posedge clock);
        chk(error_irq, 1'b1);
        ss_n_i <= 1'b1;
        wr(SPX_OFF_STAT, 8'h10);
        rd(SPX_OFF_STAT);
        chk(rv[SPX_S_MODF], 1'b0);
        // ---------------------------------------------------------------
        // Slave transfers, phase clear and phase set
        // ---------------------------------------------------------------
        for (int c = 0; c < 2; c++) begin
            wr(SPX_OFF_CTRL, 8'h00);
            wr(SPX_OFF_CTRL, c ? 8'h48 : 8'h40);
            wr(SPX_OFF_DATA, 8'h3C);
            chk(miso_oe_n, 1'b1);
            ss_n_i <= 1'b0;
            for (int i = 7; i >= 0; i--) begin
                ext_mosi <= i[0];
                repeat (3) @(posedge clock);
                chk(miso_oe_n, 1'b0);
                ext_sck <= 1'b1;
                repeat (4) @(posedge clock);
                chk(miso_o, 8'h3C >> i & 1);
                ext_sck <= 1'b0;
                @(posedge clock);
            end
            repeat (3) @(posedge clock);
            ss_n_i <= 1'b1;
            repeat (2) @(posedge clock);
            chk(miso_oe_n, 1'b1);
            rd(SPX_OFF_STAT);
            chk(rv[SPX_S_RXF], 1'b1);
            rd(SPX_OFF_DATA);
            chk(rv, 32'hAA);
        end
        end_of_test();
    end
endmodule // test_spi_master_slave_core

`default_nettype wire
